// File: src/fsyst_pkg.sv
package fsyst_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] WIN0_OFS = 8'h00;
    localparam logic [7:0] WIN1_OFS = 8'h04;
    localparam logic [7:0] WIN2_OFS = 8'h08;
    localparam logic [7:0] WIN3_OFS = 8'h0c;
    localparam logic [7:0] WIN4_OFS = 8'h10;
    localparam logic [7:0] WIN5_OFS = 8'h14;
    localparam logic [7:0] WIN6_OFS = 8'h18;
    localparam logic [7:0] CAP_OFS = 8'h1c;
    localparam logic [7:0] CLC_OFS = 8'h20;
    localparam logic [7:0] CMPA_OFS = 8'h24;
    localparam logic [7:0] CMPB_OFS = 8'h28;
    localparam logic [7:0] CMCON_OFS = 8'h2c;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h30;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h34;
    localparam logic [7:0] RST_REQ_OFS = 8'h38;

    // Clock control fields: disable bit 0, suspend bit 1, divide bits 10:8
    localparam int CLC_DIS_BIT = 0;
    localparam int CLC_SUSP_BIT = 1;
    localparam int CLC_DIV_LSB = 8;
    localparam logic [2:0] DIV_RESET = 3'h2;

    // Compare control: per compare, start bit 4:0 and width-1 4:0
    localparam int CMCON_A_POS_LSB = 0;
    localparam int CMCON_A_LEN_LSB = 8;
    localparam int CMCON_B_POS_LSB = 16;
    localparam int CMCON_B_LEN_LSB = 24;
    localparam logic [31:0] CMCON_RESET = 32'h1f00_1f00;

    // Timer reset request bit in its register
    localparam int RST_REQ_BIT = 0;

    // Window slicing of the 56-bit count
    localparam int WIN_STEP = 4;
    localparam int HIGH_LSB = 32;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pending compare events
    typedef struct packed {
        logic matchB;
        logic matchA;
    } fsyst_events_t;

endpackage : fsyst_pkg

// File: src/fsyst_timer.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1 - 56-bit up-counter, free running, one increment per timer tick.
// RULE2 - Timer tick is system clock over 3-bit divide field, reset value 010.
// RULE3 - Power-on, watchdog and software request resets clear the counter.
// RULE4 - Hardware reset pin leaves counter and divide field untouched.
// RULE5 - After a clearing reset the timer is enabled and counts at once.
// RULE6 - Timer value registers are read-only; writes never change the count.
// RULE7 - Disable or debug suspend stops the tick; registers stay readable.
// RULE8 - Reading windows zero to five latches the upper count into capture.
// RULE9 - Seven read-only 32-bit windows over rising bit ranges of the count.
// RULE10 - Two compare values, each compared continuously with the count.
// RULE11 - A match on either compare can raise an interrupt.
// RULE12 - Each compare acts on a selectable slice of the counter.
// RULE13 - Windows 0..5 start at bits 0,4..20; window six and capture hold 55:32.
module fsyst_timer #(
    parameter int CNT_W = 56
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic watchdogReset,
    input wire logic hardware_reset_pin,
    input wire logic debugSuspend,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    import fsyst_pkg::*;

    logic [CNT_W-1:0] system_time_counter_q;
    logic [2:0] clock_divide_select_q;
    logic timerDisable_q;
    logic timerSuspend_q;
    logic [2:0] divCount_q;
    logic tick;
    logic [31:0] high_part_capture_q;
    logic [31:0] compare_value_a_q;
    logic [31:0] compare_value_b_q;
    logic [31:0] cmpCtrl_q;
    logic [1:0] irqStatus_q;
    logic [1:0] irqMask_q;
    logic timer_reset_request_q;
    logic clearCount;
    fsyst_events_t events;
    logic [2:0] hwRstSync_q;
    logic hwRstActive_q;

    // Write channel state
    logic awHeld_q;
    logic wHeld_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic doWrite;
    logic wrOk;
    logic doRead;
    logic rdOk;
    logic [31:0] rdData;
    logic winRead;

    // Pin is asynchronous; change counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hwRstSync_q <= 3'h7;
            hwRstActive_q <= 1'b0;
        end
        else
        begin
            hwRstSync_q <= {hwRstSync_q[1:0], hardware_reset_pin};
            if (hwRstSync_q[2] == hwRstSync_q[1])
                hwRstActive_q <= ~hwRstSync_q[2];
        end
    end

    // Software request pulses for one cycle, then self-clears
    assign clearCount = timer_reset_request_q | watchdogReset; // RULE3

    // Tick divider; a divide value of 0 or 1 ticks every cycle
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            divCount_q <= 3'h0;
        else if (clearCount || tick)
            divCount_q <= 3'h0;
        else if (!timerDisable_q && !timerSuspend_q && !debugSuspend)
            divCount_q <= divCount_q + 3'h1;
    end

    assign tick = !timerDisable_q && !timerSuspend_q && !debugSuspend // RULE7
        && ((clock_divide_select_q <= 3'h1) || (divCount_q == clock_divide_select_q - 3'h1)); // RULE2

    // Counter: reset_n is the power-on reset; hardware pin never touches it
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            system_time_counter_q <= '0; // RULE3
        else if (clearCount)
            system_time_counter_q <= '0; // RULE3
        else if (tick)
            system_time_counter_q <= system_time_counter_q + CNT_W'(1); // RULE1
    end

    // Bus write acceptance: address and data taken in either order
    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
    assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Only control registers are writable; timer views answer with an error
    always_comb
    begin
        case ({awAddr_q[7:2], 2'b00})
            CLC_OFS, CMPA_OFS, CMPB_OFS, CMCON_OFS,
            IRQ_STAT_OFS, IRQ_MASK_OFS, RST_REQ_OFS: wrOk = 1'b1;
            default: wrOk = 1'b0; // RULE6
        endcase
    end

    // Clock control: divide field survives the hardware reset pin
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clock_divide_select_q <= DIV_RESET; // RULE2
            timerDisable_q <= 1'b0; // RULE5
            timerSuspend_q <= 1'b0;
        end
        // Any clearing reset wins over a same-cycle write, so the timer restarts enabled
        else if (clearCount)
        begin
            timerDisable_q <= 1'b0; // RULE5
            timerSuspend_q <= 1'b0; // RULE5
        end
        else if (doWrite && wrOk && awAddr_q == CLC_OFS)
        begin
            if (wStrb_q[0])
            begin
                timerDisable_q <= wData_q[CLC_DIS_BIT];
                timerSuspend_q <= wData_q[CLC_SUSP_BIT];
            end
            if (wStrb_q[1])
                clock_divide_select_q <= wData_q[CLC_DIV_LSB +: 3];
        end
    end

    // Byte-lane merge for plain writable words
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (st[i])
                r[8*i +: 8] = nw[8*i +: 8];
        return r;
    endfunction : merge

    // Compare configuration registers; the hardware pin does not clear them
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            compare_value_a_q <= 32'h0;
            compare_value_b_q <= 32'h0;
            cmpCtrl_q <= CMCON_RESET;
            irqMask_q <= 2'h0;
        end
        else if (doWrite)
        begin
            if (awAddr_q == CMPA_OFS)
                compare_value_a_q <= merge(compare_value_a_q, wData_q, wStrb_q); // RULE10
            if (awAddr_q == CMPB_OFS)
                compare_value_b_q <= merge(compare_value_b_q, wData_q, wStrb_q); // RULE10
            if (awAddr_q == CMCON_OFS)
                cmpCtrl_q <= merge(cmpCtrl_q, wData_q, wStrb_q);
            if (awAddr_q == IRQ_MASK_OFS && wStrb_q[0])
                irqMask_q <= wData_q[1:0];
        end
    end

    // Software reset request self-clears after one cycle
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            timer_reset_request_q <= 1'b0;
        else
            timer_reset_request_q <= doWrite && awAddr_q == RST_REQ_OFS
                && wStrb_q[0] && wData_q[RST_REQ_BIT]; // RULE3
    end

    // Compare on a selectable slice: start bit and width-1 per compare
    function automatic logic sliceMatch(input logic [CNT_W-1:0] cnt, input logic [31:0] cmp,
        input logic [4:0] pos, input logic [4:0] lenM1);
        logic [CNT_W-1:0] sh;
        logic [31:0] msk;
        sh = cnt >> pos;
        msk = 32'hffff_ffff >> (5'd31 - lenM1);
        return ((sh[31:0] ^ cmp) & msk) == 32'h0;
    endfunction : sliceMatch

    // Events on every tick whose new count has the slice in match
    // The next count is compared, so the event lines up with the tick itself
    assign events.matchA = tick && sliceMatch(system_time_counter_q + CNT_W'(1), compare_value_a_q,
        cmpCtrl_q[CMCON_A_POS_LSB +: 5], cmpCtrl_q[CMCON_A_LEN_LSB +: 5]); // RULE12
    assign events.matchB = tick && sliceMatch(system_time_counter_q + CNT_W'(1), compare_value_b_q,
        cmpCtrl_q[CMCON_B_POS_LSB +: 5], cmpCtrl_q[CMCON_B_LEN_LSB +: 5]); // RULE12

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            irqStatus_q <= 2'h0;
        else
        begin
            if (doWrite && awAddr_q == IRQ_STAT_OFS && wStrb_q[0])
                irqStatus_q <= (irqStatus_q & ~wData_q[1:0]) | {events.matchB, events.matchA}; // RULE11
            else
                irqStatus_q <= irqStatus_q | {events.matchB, events.matchA}; // RULE11
        end
    end

    assign irq = |(irqStatus_q & irqMask_q); // RULE11

    // Read channel; one read in flight
    assign s_axi_arready = !s_axi_rvalid;
    assign doRead = s_axi_arvalid && s_axi_arready;
    // Only aligned reads of the six lower windows refresh the capture
    assign winRead = doRead && s_axi_araddr[7:2] <= WIN5_OFS[7:2] && s_axi_araddr[1:0] == 2'b00;

    // Read mux over the windows and control registers
    always_comb
    begin
        rdOk = 1'b1;
        rdData = 32'h0;
        case ({s_axi_araddr[7:2], 2'b00})
            WIN0_OFS: rdData = system_time_counter_q[0 +: 32]; // RULE9
            WIN1_OFS: rdData = system_time_counter_q[1*WIN_STEP +: 32]; // RULE13
            WIN2_OFS: rdData = system_time_counter_q[2*WIN_STEP +: 32];
            WIN3_OFS: rdData = system_time_counter_q[3*WIN_STEP +: 32];
            WIN4_OFS: rdData = system_time_counter_q[4*WIN_STEP +: 32];
            WIN5_OFS: rdData = system_time_counter_q[5*WIN_STEP +: 32];
            WIN6_OFS: rdData = 32'(system_time_counter_q[CNT_W-1:HIGH_LSB]); // RULE13
            CAP_OFS: rdData = high_part_capture_q;
            CLC_OFS: rdData = {21'h0, clock_divide_select_q, 6'h0, timerSuspend_q | debugSuspend, timerDisable_q};
            CMPA_OFS: rdData = compare_value_a_q;
            CMPB_OFS: rdData = compare_value_b_q;
            CMCON_OFS: rdData = cmpCtrl_q;
            IRQ_STAT_OFS: rdData = {30'h0, irqStatus_q};
            IRQ_MASK_OFS: rdData = {30'h0, irqMask_q};
            RST_REQ_OFS: rdData = 32'h0;
            default: rdOk = 1'b0;
        endcase
    end

    // Capture upper count at the same edge the lower window is sampled
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            high_part_capture_q <= 32'h0;
        else if (clearCount)
            high_part_capture_q <= 32'h0;
        else if (winRead)
            high_part_capture_q <= 32'(system_time_counter_q[CNT_W-1:HIGH_LSB]); // RULE8
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (doRead)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdData;
            s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Hardware pin is observed only; by design it resets nothing here
    // Synchroniser kept so a later mode can use the pin without new timing paths
    logic unusedHw;
    assign unusedHw = hwRstActive_q; // RULE4

endmodule : fsyst_timer
`default_nettype wire

// File: tb/fsyst_timer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fsyst_timer_assertions
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    import fsyst_pkg::*;
    logic wTaken;

    // Address and data taken on the same edge
    assign wTaken = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    // Read answers one cycle after the request, write two; both stand until taken
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted");
    a_write_answer: assert property (wTaken |-> ##2 s_axi_bvalid)
        else $error("write answer missing");
    a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    // Timer value registers refuse writes
    a_window_refuse: assert property (wTaken && s_axi_awaddr <= CAP_OFS |-> ##2 s_axi_bresp == RESP_SLVERR)
        else $error("window write not refused");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h3b
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_capture_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == CAP_OFS
        |=> s_axi_rresp == RESP_OKAY)
        else $error("capture read refused");
    // Mask clears on reset, so no request right after it
    a_irq_quiet: assert property ($rose(reset_n) |-> !irq)
        else $error("interrupt out of reset");
endmodule : fsyst_timer_assertions

bind fsyst_timer fsyst_timer_assertions u_checker (
    .sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq
);
`default_nettype wire

// File: tb/fsyst_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module fsyst_timer_test;
    import fsyst_pkg::*;
    logic sys_clk = 1'b0, reset_n = 1'b0, watchdogReset = 1'b0, hardware_reset_pin = 1'b1, debugSuspend = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int badCount = 0;
    int samplesChecked = 0;

    fsyst_timer DUT (.sys_clk, .reset_n, .watchdogReset, .hardware_reset_pin, .debugSuspend,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

    // 125 MHz system clock
    always #4 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            badCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Handshakes sampled mid-cycle, so the next edge's updates never race us
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic tA, tW, tB;
        logic [1:0] r;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge sys_clk);
            tA = s_axi_awvalid & s_axi_awready;
            tW = s_axi_wvalid & s_axi_wready;
            tB = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge sys_clk);
            if (tA) s_axi_awvalid <= 1'b0;
            if (tW) s_axi_wvalid <= 1'b0;
        end while (!tB);
        s_axi_bready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        logic tA, tR;
        logic [1:0] r;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge sys_clk);
            tA = s_axi_arvalid & s_axi_arready;
            tR = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge sys_clk);
            if (tA) s_axi_arvalid <= 1'b0;
        end while (!tR);
        s_axi_rready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, RESP_OKAY, d);
        chk(d, e);
    endtask : rdc

    // Let the timer run for a while, then freeze it again
    task automatic run(input int n);
        debugSuspend <= 1'b0;
        repeat (n) @(posedge sys_clk);
        debugSuspend <= 1'b1;
    endtask : run

    task automatic waitIrq();
        debugSuspend <= 1'b0;
        repeat (200)
        begin
            @(negedge sys_clk);
            if (irq) break;
        end
        chk({31'h0, irq}, 32'h1);
        @(posedge sys_clk);
        debugSuspend <= 1'b1;
    endtask : waitIrq

    task automatic results();
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    // Hang guard, far beyond the well under two thousand cycles the tests need
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        badCount++;
        results();
    end

    // Main sequence
    initial
    begin
        logic [31:0] v, w;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        rdc(CLC_OFS, 32'h0000_0200);
        rdc(CMCON_OFS, CMCON_RESET);
        rdc(IRQ_MASK_OFS, 32'h0);
        rd(WIN0_OFS, RESP_OKAY, v);
        chk({31'h0, v != 32'h0}, 32'h1);
        debugSuspend <= 1'b1;
        // Ticks over 48 cycles for every divide code, one tick of slack for phase
        for (int n = 0; n < 8; n++)
        begin
            wr(CLC_OFS, 32'(n) << 8, RESP_OKAY);
            rd(WIN0_OFS, RESP_OKAY, v);
            run(48);
            rd(WIN0_OFS, RESP_OKAY, w);
            chk({31'h0, w - v + 32'h1 - 32'(48 / (n < 2 ? 1 : n)) <= 32'h2}, 32'h1);
        end
        wr(CLC_OFS, 32'h0000_0201, RESP_OKAY);
        debugSuspend <= 1'b0;
        rd(WIN0_OFS, RESP_OKAY, v);
        for (int k = 0; k < 8; k++)
            wr(8'(4 * k), 32'hffff_ffff, RESP_SLVERR);
        wr(8'h3c, 32'h1, RESP_SLVERR);
        for (int k = 0; k < 6; k++)
            rdc(8'(4 * k), v >> (4 * k));
        rdc(WIN6_OFS, 32'h0);
        rdc(CAP_OFS, 32'h0);
        hardware_reset_pin <= 1'b0;
        repeat (4) @(posedge sys_clk);
        hardware_reset_pin <= 1'b1;
        rdc(WIN0_OFS, v);
        rdc(CLC_OFS, 32'h0000_0201);
        // Clearing resets, taken while frozen so the count reads back exactly
        debugSuspend <= 1'b1;
        @(posedge sys_clk);
        watchdogReset <= 1'b1;
        @(posedge sys_clk);
        watchdogReset <= 1'b0;
        rdc(WIN0_OFS, 32'h0);
        rd(CLC_OFS, RESP_OKAY, v);
        chk(v & 32'h1, 32'h0);
        run(30);
        rd(WIN0_OFS, RESP_OKAY, v);
        chk({31'h0, v != 32'h0}, 32'h1);
        wr(RST_REQ_OFS, 32'h1, RESP_OKAY);
        rdc(WIN0_OFS, 32'h0);
        rdc(RST_REQ_OFS, 32'h0);
        // Suspend bit alone freezes the count; the software reset must lift it again
        wr(CLC_OFS, 32'h0000_0202, RESP_OKAY);
        run(20);
        rdc(WIN0_OFS, 32'h0);
        wr(RST_REQ_OFS, 32'h1, RESP_OKAY);
        // Four-bit slice on compare A, then full-width compare B
        wr(IRQ_STAT_OFS, 32'h3, RESP_OKAY);
        wr(CMCON_OFS, 32'h1f00_0300, RESP_OKAY);
        wr(CMPA_OFS, 32'h5, RESP_OKAY);
        wr(IRQ_MASK_OFS, 32'h1, RESP_OKAY);
        waitIrq();
        rdc(IRQ_STAT_OFS, 32'h1);
        wr(IRQ_MASK_OFS, 32'h0, RESP_OKAY);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        wr(IRQ_STAT_OFS, 32'h1, RESP_OKAY);
        rdc(IRQ_STAT_OFS, 32'h0);
        rd(WIN0_OFS, RESP_OKAY, v);
        wr(CMPB_OFS, v + 32'h3, RESP_OKAY);
        wr(IRQ_MASK_OFS, 32'h2, RESP_OKAY);
        waitIrq();
        rd(IRQ_STAT_OFS, RESP_OKAY, v);
        chk(v & 32'h2, 32'h2);
        rd(8'h3c, RESP_SLVERR, v);
        chk(v, 32'h0);
        results();
    end
endmodule : fsyst_timer_test
`default_nettype wire
